// ### drive_link_pkg.sv
// Purpose: Shared constants, types and helpers for the drive enable and status link.
// Assumes: One system clock of 250 MHz on both ends of the link.
// Notes:   Channel i-1 is axis i (1..7); then main, second and auxiliary spindle.
package drive_link_pkg;

  localparam int AXIS_CHANNELS    = 7;
  localparam int SPINDLE_CHANNELS = 3;
  localparam int CHANNELS         = AXIS_CHANNELS + SPINDLE_CHANNELS;
  localparam int SPINDLE_MAIN_IDX = AXIS_CHANNELS;
  localparam int SPINDLE_2ND_IDX  = AXIS_CHANNELS + 1;
  localparam int SPINDLE_AUX_IDX  = AXIS_CHANNELS + 2;

  // A frame is a start bit, two bits per channel, an even parity bit and a stop bit.
  localparam int DATA_BITS  = 2 * CHANNELS;
  localparam int FRAME_BITS = DATA_BITS + 1;

  localparam int CLK_PERIOD_NS       = 4;
  localparam int BIT_TIME_NS         = 16;
  localparam int BIT_CYCLES          = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FRAME_PERIOD_NS     = 2000;
  localparam int FRAME_PERIOD_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;

  localparam logic [7:0]  BIT_LAST    = 8'(BIT_CYCLES - 1);
  localparam logic [7:0]  HALF_BIT    = 8'(BIT_CYCLES / 2 - 1);
  localparam logic [4:0]  IDX_LAST    = 5'(FRAME_BITS - 1);
  localparam logic [4:0]  TX_BITS     = 5'(FRAME_BITS + 2);
  localparam logic [15:0] PERIOD_LAST = 16'(FRAME_PERIOD_CYCLES - 1);

  // Status codes written as {state_bit_first, state_bit_second}.
  localparam logic [1:0] ST_NOT_READY = 2'h0;
  localparam logic [1:0] ST_BUS_READY = 2'h1;
  localparam logic [1:0] ST_ACCEPT    = 2'h2;
  localparam logic [1:0] ST_RUNNING   = 2'h3;

  localparam logic [7:0] ADDR_SPEED_REQ  = 8'h00;
  localparam logic [7:0] ADDR_POWER_REQ  = 8'h04;
  localparam logic [7:0] ADDR_STATE_1ST  = 8'h08;
  localparam logic [7:0] ADDR_STATE_2ND  = 8'h0c;
  localparam logic [7:0] ADDR_LINK_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_LINK_STAT  = 8'h14;
  localparam int         CTRL_RUN_BIT    = 0;
  localparam int         STAT_ERR_BIT    = 16;
  localparam int         STAT_MISS_BIT   = 17;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_t;

  function automatic logic [DATA_BITS-1:0] pack_pairs(input logic [CHANNELS-1:0] lo,
                                                      input logic [CHANNELS-1:0] hi);
    logic [DATA_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      r[2*i]   = lo[i];
      r[2*i+1] = hi[i];
    end
    return r;
  endfunction

  function automatic logic [CHANNELS-1:0] pair_lo(input logic [DATA_BITS-1:0] d);
    logic [CHANNELS-1:0] r;
    r = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      r[i] = d[2*i];
    end
    return r;
  endfunction

  function automatic logic [CHANNELS-1:0] pair_hi(input logic [DATA_BITS-1:0] d);
    logic [CHANNELS-1:0] r;
    r = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      r[i] = d[2*i+1];
    end
    return r;
  endfunction

  function automatic logic [1:0] drive_state(input logic ready, input logic bus,
                                             input logic spd, input logic drv);
    if (!ready) begin
      return ST_NOT_READY;
    end else if (!bus) begin
      return ST_BUS_READY;
    end else if (spd && drv) begin
      return ST_RUNNING;
    end
    return ST_ACCEPT;
  endfunction

endpackage

// ### drive_link_if.sv
// Purpose: Serial fieldbus lines between the controller end and the drive end.
// Assumes: Both ends run on the same system clock; lines idle high.
// Notes:   Each line has exactly one driver, the modport that outputs it.
`timescale 1ns/1ps
interface drive_link_if;
  logic cmd_line;
  logic reply_line;
  modport controller (output cmd_line, input reply_line);
  modport drive (input cmd_line, output reply_line);
endinterface

// ### drive_end.sv
// Purpose: Drive end: takes enable requests off the link and reports status.
// Assumes: Enable and status pins are asynchronous; the link shares clk_sys_in.
// Notes:   Hardwired enables act at once; reported status moves per frame.
//
// What this block does
// - Speed request and pins low: zero velocity.
// - Speed request high enables velocity command.
// - Drive request and pin low: no torque.
// - Speed function is request OR pin.
// - Modular drives also OR supply speed enable.
// - Drive function is request OR pin.
// - Integrator keeps hardwired drive enable path.
// - Requests travel over the serial fieldbus.
// - Seven axis plus three spindle request pairs.
// - Two status bits per channel reported.
// - Code 00: not ready, no mains.
// - Code 01: ready for bus power.
// - Code 10: accepts enables, controller enables.
// - Code 11: both functions active, motor follows.
// - Axis channels follow axis-letter order.
// - Spindle channels: main, second, auxiliary.
`timescale 1ns/1ps
module drive_end #(
  parameter bit MODULAR_DRIVE = 1'b1
) (
  input  wire logic                                 clk_sys_in,
  input  wire logic                                 rst_in,
  drive_link_if.drive                               link,
  input  wire logic [drive_link_pkg::CHANNELS-1:0] velocity_enable_pin_in,
  input  wire logic [drive_link_pkg::CHANNELS-1:0] power_stage_enable_pin_in,
  input  wire logic                                 supply_velocity_enable_pin_in,
  input  wire logic [drive_link_pkg::CHANNELS-1:0] logic_ready_pin_in,
  input  wire logic [drive_link_pkg::CHANNELS-1:0] bus_power_pin_in,
  output logic      [drive_link_pkg::CHANNELS-1:0] velocity_command_enable_out,
  output logic      [drive_link_pkg::CHANNELS-1:0] torque_enable_out,
  output logic      [drive_link_pkg::CHANNELS-1:0] state_bit_first_out,
  output logic      [drive_link_pkg::CHANNELS-1:0] state_bit_second_out,
  output logic                                      link_fault_out
);
  import drive_link_pkg::*;

  localparam int PIN_W = 4 * CHANNELS + 1;

  logic [PIN_W-1:0]      pin_meta_q;
  logic [PIN_W-1:0]      pin_sync_q;
  wire  [PIN_W-1:0]      pin_raw;
  wire  [CHANNELS-1:0]   vel_pin_s;
  wire  [CHANNELS-1:0]   pwr_pin_s;
  wire  [CHANNELS-1:0]   ready_s;
  wire  [CHANNELS-1:0]   bus_s;
  wire                   supply_s;

  // Pins pass two flip-flops; only the second one is read by any logic.
  assign pin_raw = {supply_velocity_enable_pin_in, bus_power_pin_in, logic_ready_pin_in,
                    power_stage_enable_pin_in, velocity_enable_pin_in};
  assign vel_pin_s = pin_sync_q[CHANNELS-1:0];
  assign pwr_pin_s = pin_sync_q[2*CHANNELS-1:CHANNELS];
  assign ready_s   = pin_sync_q[3*CHANNELS-1:2*CHANNELS];
  assign bus_s     = pin_sync_q[4*CHANNELS-1:3*CHANNELS];
  assign supply_s  = pin_sync_q[4*CHANNELS];

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Receiver for command frames.
  rx_state_t             rx_q;
  logic [7:0]            rx_tick_q;
  logic [4:0]            rx_idx_q;
  logic [FRAME_BITS-1:0] rx_sh_q;
  logic                  rx_good_q;
  logic                  rx_bad_q;
  wire                   cmd_bit;
  wire                   rx_tick_done;
  wire                   parity_ok;

  assign cmd_bit      = link.cmd_line;
  assign rx_tick_done = rx_tick_q == 8'h00;
  assign parity_ok    = ~(^rx_sh_q);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_q      <= RX_IDLE;
      rx_tick_q <= 8'h00;
      rx_idx_q  <= 5'h00;
      rx_sh_q   <= '0;
      rx_good_q <= 1'b0;
      rx_bad_q  <= 1'b0;
    end else begin
      rx_good_q <= 1'b0;
      rx_bad_q  <= 1'b0;
      case (rx_q)
        RX_IDLE: begin
          if (!cmd_bit) begin
            rx_q      <= RX_START;
            rx_tick_q <= HALF_BIT;
          end
        end
        RX_START: begin
          if (!rx_tick_done) begin
            rx_tick_q <= rx_tick_q - 8'h01;
          end else if (!cmd_bit) begin
            rx_q      <= RX_DATA;
            rx_tick_q <= BIT_LAST;
            rx_idx_q  <= 5'h00;
          end else begin
            rx_q <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (!rx_tick_done) begin
            rx_tick_q <= rx_tick_q - 8'h01;
          end else begin
            rx_sh_q   <= {cmd_bit, rx_sh_q[FRAME_BITS-1:1]};
            rx_tick_q <= BIT_LAST;
            rx_idx_q  <= rx_idx_q + 5'h01;
            if (rx_idx_q == IDX_LAST) begin
              rx_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (!rx_tick_done) begin
            rx_tick_q <= rx_tick_q - 8'h01;
          end else begin
            rx_q      <= RX_IDLE;
            rx_good_q <= cmd_bit & parity_ok;
            rx_bad_q  <= ~(cmd_bit & parity_ok);
          end
        end
        default: begin
          rx_q <= RX_IDLE;
        end
      endcase
    end
  end

  // Requests held from the last good frame; a damaged frame leaves them as they were.
  logic [CHANNELS-1:0] speed_req_q;
  logic [CHANNELS-1:0] power_req_q;
  logic                reply_load_q;
  logic                link_fault_q;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      speed_req_q  <= '0;
      power_req_q  <= '0;
      reply_load_q <= 1'b0;
      link_fault_q <= 1'b0;
    end else begin
      reply_load_q <= rx_good_q;
      if (rx_good_q) begin
        speed_req_q  <= pair_lo(rx_sh_q[DATA_BITS-1:0]);
        power_req_q  <= pair_hi(rx_sh_q[DATA_BITS-1:0]);
        link_fault_q <= 1'b0;
      end else if (rx_bad_q) begin
        link_fault_q <= 1'b1;
      end
    end
  end

  wire [CHANNELS-1:0] speed_fn;
  wire [CHANNELS-1:0] drive_fn;
  wire [CHANNELS-1:0] velocity_d;
  wire [CHANNELS-1:0] torque_d;

  // The bus request only adds to the hardwired paths; it never masks them.
  assign speed_fn = speed_req_q | vel_pin_s
                  | {CHANNELS{MODULAR_DRIVE & supply_s}};
  assign drive_fn = power_req_q | pwr_pin_s;
  assign velocity_d = speed_fn & ready_s;
  assign torque_d   = drive_fn & ready_s & bus_s;

  logic [CHANNELS-1:0] first_d;
  logic [CHANNELS-1:0] second_d;

  always_comb begin
    first_d  = '0;
    second_d = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      // Codes 00, 01, 10 and 11 in order of readiness.
      {first_d[i], second_d[i]} = drive_state(ready_s[i], bus_s[i],
                                              speed_fn[i], drive_fn[i]);
    end
  end

  logic [CHANNELS-1:0] velocity_q;
  logic [CHANNELS-1:0] torque_q;
  logic [CHANNELS-1:0] first_q;
  logic [CHANNELS-1:0] second_q;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      velocity_q <= '0;
      torque_q   <= '0;
      first_q    <= '0;
      second_q   <= '0;
    end else begin
      velocity_q <= velocity_d;
      torque_q   <= torque_d;
      // Status is taken once per frame, after the new requests have landed.
      if (reply_load_q) begin
        first_q  <= first_d;
        second_q <= second_d;
      end
    end
  end

  // Reply transmitter; the line is the low bit of the shifter, all ones when idle.
  logic [FRAME_BITS+1:0] tx_sh_q;
  logic [4:0]            tx_left_q;
  logic [7:0]            tx_tick_q;
  wire  [DATA_BITS-1:0]  reply_data;

  assign reply_data = pack_pairs(first_d, second_d);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tx_sh_q   <= '1;
      tx_left_q <= 5'h00;
      tx_tick_q <= 8'h00;
    end else if (reply_load_q) begin
      tx_sh_q   <= {1'b1, ^reply_data, reply_data, 1'b0};
      tx_left_q <= TX_BITS;
      tx_tick_q <= BIT_LAST;
    end else if (tx_left_q != 5'h00) begin
      if (tx_tick_q == 8'h00) begin
        tx_sh_q   <= {1'b1, tx_sh_q[FRAME_BITS+1:1]};
        tx_left_q <= tx_left_q - 5'h01;
        tx_tick_q <= BIT_LAST;
      end else begin
        tx_tick_q <= tx_tick_q - 8'h01;
      end
    end
  end

  assign link.reply_line             = tx_sh_q[0];
  assign velocity_command_enable_out = velocity_q;
  assign torque_enable_out           = torque_q;
  assign state_bit_first_out         = first_q;
  assign state_bit_second_out        = second_q;
  assign link_fault_out              = link_fault_q;

endmodule

// ### controller_end.sv
// Purpose: Controller end: software writes enable requests, reads drive status.
// Assumes: Classic Wishbone slave on clk_sys_in; link shares the same clock.
// Notes:   Frames go out every frame period while the run bit is set.
`timescale 1ns/1ps
module controller_end (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  drive_link_if.controller link,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out
);
  import drive_link_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic [CHANNELS-1:0] speed_req_q;
  logic [CHANNELS-1:0] power_req_q;
  logic [CHANNELS-1:0] first_q;
  logic [CHANNELS-1:0] second_q;
  logic                run_q;
  logic [15:0]         good_cnt_q;
  logic                err_q;
  logic                miss_q;
  logic                ack_q;
  logic [31:0]         dat_q;

  wire        wb_req = wb_cyc_in & wb_stb_in & ~ack_q;
  wire        wr     = wb_req & wb_we_in;
  wire        hit_sp = wb_adr_in == ADDR_SPEED_REQ;
  wire        hit_pw = wb_adr_in == ADDR_POWER_REQ;
  wire        hit_f  = wb_adr_in == ADDR_STATE_1ST;
  wire        hit_s  = wb_adr_in == ADDR_STATE_2ND;
  wire        hit_c  = wb_adr_in == ADDR_LINK_CTRL;
  wire        hit_st = wb_adr_in == ADDR_LINK_STAT;
  wire [31:0] sp_w   = {{(32-CHANNELS){1'b0}}, speed_req_q};
  wire [31:0] pw_w   = {{(32-CHANNELS){1'b0}}, power_req_q};
  wire [31:0] ctl_w  = {31'h0, run_q};
  wire [31:0] st_w   = {14'h0, miss_q, err_q, good_cnt_q};
  wire [31:0] sp_m   = merge(sp_w, wb_dat_in, wb_sel_in);
  wire [31:0] pw_m   = merge(pw_w, wb_dat_in, wb_sel_in);
  wire [31:0] ctl_m  = merge(ctl_w, wb_dat_in, wb_sel_in);
  wire [31:0] w1c    = (wr & hit_st) ? merge(32'h0, wb_dat_in, wb_sel_in) : 32'h0;
  // Unmapped addresses read zero and ignore writes, but are still acknowledged.
  wire [31:0] rd     = hit_sp ? sp_w :
                       hit_pw ? pw_w :
                       hit_f  ? {{(32-CHANNELS){1'b0}}, first_q} :
                       hit_s  ? {{(32-CHANNELS){1'b0}}, second_q} :
                       hit_c  ? ctl_w :
                       hit_st ? st_w : 32'h0;

  // Receiver for reply frames.
  rx_state_t             rx_q;
  logic [7:0]            rx_tick_q;
  logic [4:0]            rx_idx_q;
  logic [FRAME_BITS-1:0] rx_sh_q;
  logic                  rx_good_q;
  logic                  rx_bad_q;
  wire                   in_bit = link.reply_line;
  wire                   tick0  = rx_tick_q == 8'h00;
  wire                   par_ok = ~(^rx_sh_q);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_q      <= RX_IDLE;
      rx_tick_q <= 8'h00;
      rx_idx_q  <= 5'h00;
      rx_sh_q   <= '0;
      rx_good_q <= 1'b0;
      rx_bad_q  <= 1'b0;
    end else begin
      rx_good_q <= 1'b0;
      rx_bad_q  <= 1'b0;
      case (rx_q)
        RX_IDLE: begin
          if (!in_bit) begin
            rx_q      <= RX_START;
            rx_tick_q <= HALF_BIT;
          end
        end
        RX_START: begin
          if (!tick0) begin
            rx_tick_q <= rx_tick_q - 8'h01;
          end else if (!in_bit) begin
            rx_q      <= RX_DATA;
            rx_tick_q <= BIT_LAST;
            rx_idx_q  <= 5'h00;
          end else begin
            rx_q <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (!tick0) begin
            rx_tick_q <= rx_tick_q - 8'h01;
          end else begin
            rx_sh_q   <= {in_bit, rx_sh_q[FRAME_BITS-1:1]};
            rx_tick_q <= BIT_LAST;
            rx_idx_q  <= rx_idx_q + 5'h01;
            if (rx_idx_q == IDX_LAST) begin
              rx_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (!tick0) begin
            rx_tick_q <= rx_tick_q - 8'h01;
          end else begin
            rx_q      <= RX_IDLE;
            rx_good_q <= in_bit & par_ok;
            rx_bad_q  <= ~(in_bit & par_ok);
          end
        end
        default: begin
          rx_q <= RX_IDLE;
        end
      endcase
    end
  end

  // Frame timer and transmitter.
  logic [15:0]           period_q;
  logic                  await_q;
  logic [FRAME_BITS+1:0] tx_sh_q;
  logic [4:0]            tx_left_q;
  logic [7:0]            tx_tick_q;
  wire                   send = run_q & (period_q == 16'h0000);
  wire [DATA_BITS-1:0]   cmd_data = pack_pairs(speed_req_q, power_req_q);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      period_q  <= 16'h0000;
      tx_sh_q   <= '1;
      tx_left_q <= 5'h00;
      tx_tick_q <= 8'h00;
    end else begin
      if (!run_q || send) begin
        period_q <= run_q ? PERIOD_LAST : 16'h0000;
      end else begin
        period_q <= period_q - 16'h0001;
      end
      if (send) begin
        tx_sh_q   <= {1'b1, ^cmd_data, cmd_data, 1'b0};
        tx_left_q <= TX_BITS;
        tx_tick_q <= BIT_LAST;
      end else if (tx_left_q != 5'h00) begin
        if (tx_tick_q == 8'h00) begin
          tx_sh_q   <= {1'b1, tx_sh_q[FRAME_BITS+1:1]};
          tx_left_q <= tx_left_q - 5'h01;
          tx_tick_q <= BIT_LAST;
        end else begin
          tx_tick_q <= tx_tick_q - 8'h01;
        end
      end
    end
  end

  // Registers; hardware sets of the sticky flags win over a clearing write.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      speed_req_q <= '0;
      power_req_q <= '0;
      run_q       <= 1'b0;
      first_q     <= '0;
      second_q    <= '0;
      good_cnt_q  <= 16'h0000;
      err_q       <= 1'b0;
      miss_q      <= 1'b0;
      await_q     <= 1'b0;
      ack_q       <= 1'b0;
      dat_q       <= 32'h0;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        dat_q <= rd;
      end
      if (wr && hit_sp) begin
        speed_req_q <= sp_m[CHANNELS-1:0];
      end
      if (wr && hit_pw) begin
        power_req_q <= pw_m[CHANNELS-1:0];
      end
      if (wr && hit_c) begin
        run_q <= ctl_m[CTRL_RUN_BIT];
      end
      if (rx_good_q) begin
        first_q    <= pair_lo(rx_sh_q[DATA_BITS-1:0]);
        second_q   <= pair_hi(rx_sh_q[DATA_BITS-1:0]);
        good_cnt_q <= good_cnt_q + 16'h0001;
      end
      err_q   <= rx_bad_q | (err_q & ~w1c[STAT_ERR_BIT]);
      miss_q  <= (send & await_q) | (miss_q & ~w1c[STAT_MISS_BIT]);
      await_q <= send | (await_q & ~rx_good_q & ~rx_bad_q);
    end
  end

  assign link.cmd_line = tx_sh_q[0];
  assign wb_dat_out    = dat_q;
  assign wb_ack_out    = ack_q;

endmodule

// ### link_wire_asserts.sv
// Purpose: Wire-level checks on the command and reply lines of the link.
// Assumes: One clock; a frame is 23 bits of 4 cycles each, frames 500 cycles apart.
// Notes:   Frame starts are found by counting, since data bits can fall as well.
`timescale 1ns/1ps
module link_wire_asserts (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic cmd_line,
  input wire logic reply_line
);
  logic       cmd_prev_q;
  logic       reply_prev_q;
  logic [6:0] cmd_cnt_q;
  logic [6:0] reply_cnt_q;
  logic [9:0] since_cmd_q;
  wire        cmd_go      = cmd_prev_q & ~cmd_line & (cmd_cnt_q == 7'h0);
  wire        reply_go    = reply_prev_q & ~reply_line & (reply_cnt_q == 7'h0);
  wire  [6:0] cmd_cnt_d   = cmd_go ? 7'h5b : cmd_cnt_q - {6'h0, cmd_cnt_q != 7'h0};
  wire  [6:0] reply_cnt_d = reply_go ? 7'h5b : reply_cnt_q - {6'h0, reply_cnt_q != 7'h0};
  wire  [9:0] since_cmd_d = cmd_go ? 10'h1 : since_cmd_q + {9'h0, since_cmd_q != 10'h3ff};

  // The gap counter saturates so that a reply with no command before it is caught.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_prev_q   <= 1'b1;
      reply_prev_q <= 1'b1;
      cmd_cnt_q    <= 7'h0;
      reply_cnt_q  <= 7'h0;
      since_cmd_q  <= 10'h3ff;
    end else begin
      cmd_prev_q   <= cmd_line;
      reply_prev_q <= reply_line;
      cmd_cnt_q    <= cmd_cnt_d;
      reply_cnt_q  <= reply_cnt_d;
      since_cmd_q  <= since_cmd_d;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  property p_cmd_low; $fell(cmd_line) |-> !cmd_line [*4]; endproperty
  a_cmd_low: assert property (p_cmd_low) else $error("command low bit too short");
  property p_cmd_high; $rose(cmd_line) |-> cmd_line [*4]; endproperty
  a_cmd_high: assert property (p_cmd_high) else $error("command high bit too short");
  property p_reply_low; $fell(reply_line) |-> !reply_line [*4]; endproperty
  a_reply_low: assert property (p_reply_low) else $error("reply low bit too short");
  property p_reply_high; $rose(reply_line) |-> reply_line [*4]; endproperty
  a_reply_high: assert property (p_reply_high) else $error("reply high bit too short");
  property p_cmd_stop; cmd_go |-> ##88 cmd_line [*4]; endproperty
  a_cmd_stop: assert property (p_cmd_stop) else $error("command stop bit missing");
  property p_reply_stop; reply_go |-> ##88 reply_line [*4]; endproperty
  a_reply_stop: assert property (p_reply_stop) else $error("reply stop bit missing");
  property p_reply_due; cmd_go |-> ##[89:127] reply_go; endproperty
  a_reply_due: assert property (p_reply_due) else $error("no reply to command");
  property p_reply_cause; reply_go |-> since_cmd_q inside {[10'h59:10'h7f]}; endproperty
  a_reply_cause: assert property (p_reply_cause) else $error("reply out of turn");
  property p_period; cmd_go && since_cmd_q != 10'h3ff |-> since_cmd_q == 10'h1f4; endproperty
  a_period: assert property (p_period) else $error("frame period wrong");
endmodule

// ### tb.sv
// Purpose: Self-checking bench for the controller and drive ends joined by the link.
// Assumes: Both ends share clk_sys_in; the drive is built as a modular drive.
// Notes:   Each wait spans two frame periods so a fresh reply is always seen.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb;
  import drive_link_pkg::*;
  logic                  clk_sys_in, rst_in, cyc, stb, we, ack, sup, fault;
  logic [7:0]            adr;
  logic [3:0]            sel;
  logic [31:0]           wdat, rdat, q;
  logic [CHANNELS-1:0]   vpin, ppin, rdy, bus, vel, trq, sf, ss, sreq, preq;
  logic [4*CHANNELS-1:0] e;
  int                    fails, samples_checked;

  drive_link_if drive_link_if_i ();
  controller_end controller_end_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .link(drive_link_if_i.controller), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel), .wb_dat_out(rdat), .wb_ack_out(ack));
  drive_end #(.MODULAR_DRIVE(1'b1)) drive_end_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .link(drive_link_if_i.drive), .velocity_enable_pin_in(vpin),
    .power_stage_enable_pin_in(ppin), .supply_velocity_enable_pin_in(sup),
    .logic_ready_pin_in(rdy), .bus_power_pin_in(bus), .velocity_command_enable_out(vel),
    .torque_enable_out(trq), .state_bit_first_out(sf), .state_bit_second_out(ss),
    .link_fault_out(fault));
  link_wire_asserts link_wire_asserts_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .cmd_line(drive_link_if_i.cmd_line), .reply_line(drive_link_if_i.reply_line));

  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Called just after a rising edge; leaves one idle cycle before returning.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (ack !== 1'b1 && n < 64);
    r = rdat;
    if (ack !== 1'b1) begin
      fails++;
      complete_run();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  function automatic logic [CHANNELS-1:0] pick(input int it);
    if (it < 2)
      return {CHANNELS{it[0]}};
    return CHANNELS'($urandom);
  endfunction

  // Returns velocity, torque, first and second state vectors, in that order.
  function automatic logic [4*CHANNELS-1:0] expect_all();
    logic [CHANNELS-1:0] spd, drv;
    spd = sreq | vpin | {CHANNELS{sup}};
    drv = preq | ppin;
    return {spd & rdy, drv & rdy & bus, rdy & bus, rdy & (~bus | (spd & drv))};
  endfunction

  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    {rst_in, cyc, stb, we, adr, wdat, sel, sup} = {1'b1, 48'h0};
    {vpin, ppin, rdy, bus, sreq, preq} = '0;
    fails = 0;
    samples_checked = 0;
    void'($urandom(32));
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    wb(1'b1, 8'h20, 32'hffffffff, q);
    wb(1'b0, 8'h20, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    wb(1'b1, ADDR_LINK_CTRL, 32'h1, q);
    for (int it = 0; it < 16; it++) begin
      sreq = pick(it);
      preq = pick(it);
      vpin <= pick(it);
      ppin <= pick(it);
      rdy <= pick(it) | pick(it);
      bus <= pick(it) | pick(it);
      sup <= (it > 1) && ($urandom % 3 == 0);
      wb(1'b1, ADDR_SPEED_REQ, 32'(sreq), q);
      wb(1'b1, ADDR_POWER_REQ, 32'(preq), q);
      wb(1'b0, ADDR_SPEED_REQ, 32'h0, q);
      `CHK("speed request", 32'(sreq), q)
      repeat (1100) @(posedge clk_sys_in);
      e = expect_all();
      `CHK("velocity", e[4*CHANNELS-1:3*CHANNELS], vel)
      `CHK("torque", e[3*CHANNELS-1:2*CHANNELS], trq)
      `CHK("state", e[2*CHANNELS-1:0], {sf, ss})
      wb(1'b1, ADDR_STATE_1ST, 32'hffffffff, q);
      wb(1'b0, ADDR_STATE_1ST, 32'h0, q);
      `CHK("first state reg", 32'(e[2*CHANNELS-1:CHANNELS]), q)
      `CHK("first axis first", e[CHANNELS], q[0])
      `CHK("main spindle first", e[CHANNELS+SPINDLE_MAIN_IDX], q[SPINDLE_MAIN_IDX])
      `CHK("second spindle first", e[CHANNELS+SPINDLE_2ND_IDX], q[SPINDLE_2ND_IDX])
      `CHK("aux spindle first", e[CHANNELS+SPINDLE_AUX_IDX], q[SPINDLE_AUX_IDX])
      wb(1'b0, ADDR_STATE_2ND, 32'h0, q);
      `CHK("second state reg", 32'(e[CHANNELS-1:0]), q)
      wb(1'b0, ADDR_LINK_STAT, 32'h0, q);
      `CHK("link errors", 2'h0, q[17:16])
      `CHK("link fault", 1'b0, fault)
    end
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    `CHK("outputs in reset", 40'h0, {vel, trq, sf, ss})
    `CHK("command idle", 1'b1, drive_link_if_i.cmd_line)
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    wb(1'b0, ADDR_LINK_CTRL, 32'h0, q);
    `CHK("run after reset", 32'h0, q)
    complete_run();
  end
endmodule
